// ==== logic/dbg_link_host.sv ====
// Host (pod) end of the single-wire debug bit link
`timescale 1ns/100ps
module dbg_link_host
	import dbg_link_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Link
	dbg_link_if.host        link,
	// User side
	input  wire logic       req_valid,
	input  wire logic       req_read,
	input  wire logic       req_sync,
	input  wire logic [7:0] req_byte,
	input  wire logic [CNT_W-1:0] bit_time,
	output logic            req_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_byte,
	output logic [CNT_W-1:0] sync_len
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_BIT  = 2'b01,
		H_SYNC = 2'b10,
		H_SYRX = 2'b11
	} hstate_t;

	hstate_t          st_reg, st_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next, len_reg, len_next;
	logic [2:0]       bit_reg, bit_next;
	logic [7:0]       sh_reg, sh_next;
	logic             rd_reg, rd_next, rv_reg, rv_next;
	logic             out_next, oen_next, out_reg, oen_reg;
	logic             seen_reg, seen_next;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg + 1'b1;
		len_next = len_reg;
		bit_next = bit_reg;
		sh_next  = sh_reg;
		rd_next  = rd_reg;
		rv_next  = 1'b0;
		seen_next = seen_reg;
		out_next = 1'b0;
		oen_next = 1'b1;
		case (st_reg)
			H_IDLE: begin
				cnt_next = '0;
				if (req_valid && req_sync) begin
					st_next = H_SYNC;
				end else if (req_valid) begin
					st_next = H_BIT;
					sh_next = req_byte;
					rd_next = req_read;
					bit_next = '0;
				end
			end
			H_BIT: begin
				// Falling edge opens every bit (RULE1)
				if (rd_reg) begin
					oen_next = !(cnt_reg < CNT_W'(HOST_LOW_CYCLES + 1)); // RULE7
				end else begin
					oen_next = 1'b0; // RULE6
					// Back high before the bit ends, so two zeros still give an edge
					out_next = (cnt_reg == '0) ? 1'b0 :
						(cnt_reg >= CNT_W'(ZERO_LOW_CYCLES)) ? 1'b1 : sh_reg[7]; // RULE2
				end
				if (rd_reg && cnt_reg == CNT_W'(HOST_SAMPLE_AT)) begin
					sh_next = {sh_reg[6:0], link.debug_pin}; // RULE10
				end
				if (cnt_reg == bit_time - 1'b1) begin
					cnt_next = '0;
					bit_next = bit_reg + 1'b1;
					if (!rd_reg) begin
						sh_next = {sh_reg[6:0], 1'b0};
					end
					if (bit_reg == 3'd7) begin
						st_next = H_IDLE;
						rv_next = rd_reg;
					end
				end
			end
			H_SYNC: begin
				oen_next = 1'b0; // RULE16
				if (cnt_reg == CNT_W'(SYNC_DETECT + 2)) begin
					out_next = 1'b1;
					st_next  = H_SYRX;
					cnt_next = '0;
					seen_next = 1'b0;
				end
			end
			H_SYRX: begin
				if (!link.debug_pin) begin
					seen_next = 1'b1;
					// The first low cycle already counts as one
					if (!seen_reg) begin
						cnt_next = CNT_W'(1);
					end
				end else if (seen_reg) begin
					len_next = cnt_reg;
					st_next  = H_IDLE;
				end
			end
			default: begin
				st_next = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg   <= H_IDLE;
			cnt_reg  <= '0;
			len_reg  <= '0;
			bit_reg  <= '0;
			sh_reg   <= 8'h00;
			rd_reg   <= 1'b0;
			rv_reg   <= 1'b0;
			seen_reg <= 1'b0;
			out_reg  <= 1'b0;
			oen_reg  <= 1'b1;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			len_reg  <= len_next;
			bit_reg  <= bit_next;
			sh_reg   <= sh_next;
			rd_reg   <= rd_next;
			rv_reg   <= rv_next;
			seen_reg <= seen_next;
			out_reg  <= out_next;
			oen_reg  <= oen_next;
		end
	end

	assign link.host_pin_out  = out_reg;
	assign link.host_pin_oe_n = oen_reg;
	assign req_ready = (st_reg == H_IDLE);
	assign rsp_valid = rv_reg;
	assign rsp_byte  = sh_reg;
	assign sync_len  = len_reg;
endmodule

// ==== logic/dbg_link_target.sv ====
// Target end of the single-wire debug bit link
// Summary of operation
// RULE1 - Host starts every bit with falling edge
// RULE2 - Sixteen cycles per bit, MSB first
// RULE3 - 512 idle cycles abort current command
// RULE4 - Control bit selects bus or alternate clock
// RULE5 - Detect start, sample host bit at ten
// RULE6 - Target leaves line undriven while host sends
// RULE7 - Host holds low two, releases early; the host code holds it low three cycles (count 0 to 2)
// RULE8 - Logic one: speedup pulse at seven
// RULE9 - Logic zero: low thirteen, then pulse high
// RULE10 - Host samples returned bit near ten
// RULE11 - Active commands only in background mode
// RULE12 - Pin at reset picks background mode
// RULE13 - Link works without prior reset
// RULE14 - Pseudo open drain with driven speedup
// RULE15 - Answer sync request with timed pulse
// RULE16 - Host sync request is long low
// RULE17 - Sync reply: delay, low 128, pulse
// RULE18 - Eight-bit command code, then delay
// RULE19 - Synchronise pin, detect falling edge
`timescale 1ns/100ps
module dbg_link_target
	import dbg_link_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYCLES
) (
	// Clocks and reset
	input  wire logic       clk,
	input  wire logic       alt_clk,
	input  wire logic       rst,
	// Link
	dbg_link_if.target      link,
	// User side
	input  wire logic [7:0] debug_status_control,
	output logic            debug_clock_source_select,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            cmd_valid,
	output logic [7:0]      cmd_code,
	output logic            cmd_rejected,
	output logic            cmd_abort,
	output logic            sync_done,
	input  wire logic       cmd_start,
	input  wire logic       enter_background,
	input  wire logic       leave_background,
	output logic            active_background_mode
);
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_RXBIT = 3'b001,
		S_TXBIT = 3'b010,
		S_SYWT  = 3'b011,
		S_SYDL  = 3'b100,
		S_SYLO  = 3'b101,
		S_SYHI  = 3'b110
	} tstate_t;

	// Clock selection is made outside; this port tells the clock mux (RULE4)
	assign debug_clock_source_select = debug_status_control[DSC_CLKSEL_BIT]; // RULE4

	logic            sync1_reg, sync2_reg, prev_reg;
	tstate_t         st_reg, st_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] idle_reg, idle_next;
	logic [2:0]      bit_reg, bit_next;
	logic [7:0]      sh_reg, sh_next;
	logic [7:0]      tx_reg, tx_next;
	logic            txon_reg, txon_next;
	logic            first_reg, first_next;
	logic            abm_reg, abm_next;
	logic            boot_reg;
	logic            out_reg, out_next, oen_reg, oen_next;
	logic            rxv_reg, rxv_next, cv_reg, cv_next, rj_reg, rj_next;
	logic            ab_reg, ab_next, sd_reg, sd_next;
	logic            fall;

	// First stage feeds only the second (RULE19)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end else begin
			sync1_reg <= link.debug_pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end
	assign fall = prev_reg & ~sync2_reg; // RULE19 RULE1

	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		idle_next = (fall || idle_reg == CNT_W'(TIMEOUT)) ? '0 : idle_reg + 1'b1;
		bit_next  = bit_reg;
		sh_next   = sh_reg;
		tx_next   = tx_reg;
		txon_next = txon_reg;
		first_next = first_reg;
		abm_next  = abm_reg;
		out_next  = 1'b0;
		oen_next  = 1'b1; // RULE6 RULE14
		rxv_next  = 1'b0;
		cv_next   = 1'b0;
		rj_next   = 1'b0;
		ab_next   = 1'b0;
		sd_next   = 1'b0;
		if (enter_background) begin
			abm_next = 1'b1;
		end else if (leave_background) begin
			abm_next = 1'b0;
		end
		if (tx_valid && !txon_reg) begin
			tx_next   = tx_byte;
			txon_next = 1'b1;
		end
		case (st_reg)
			S_IDLE: begin
				if (fall) begin
					st_next  = txon_reg ? S_TXBIT : S_RXBIT; // RULE5
					cnt_next = '0;
					// A zero starts its low drive at once, joining the host's low
					if (txon_reg && !tx_reg[7]) begin
						oen_next = 1'b0; // RULE9
					end
				end
			end
			S_RXBIT: begin
				cnt_next = cnt_reg + 1'b1;
				if (!sync2_reg && cnt_reg >= CNT_W'(SYNC_DETECT)) begin
					st_next = S_SYWT; // RULE15
				end else if (cnt_reg == CNT_W'(SAMPLE_AT - 1)) begin
					sh_next = {sh_reg[6:0], sync2_reg}; // RULE5 RULE2
					bit_next = bit_reg + 1'b1;
					if (bit_reg == 3'd7) begin
						if (first_reg) begin
							first_next = 1'b0;
							// Active group is a nonzero code with its top bit clear
							if (!abm_reg && ({sh_reg[6:0], sync2_reg} != 8'h00)
								&& (({sh_reg[6:0], sync2_reg} & CMD_ACTIVE_MASK) == 8'h00)) begin
								rj_next = 1'b1; // RULE11
							end else begin
								cv_next = 1'b1; // RULE18
							end
						end else begin
							rxv_next = 1'b1;
						end
					end
				end else if (cnt_reg >= CNT_W'(BIT_CYCLES - 1) && sync2_reg) begin
					st_next = S_IDLE;
				end
			end
			S_TXBIT: begin
				cnt_next = cnt_reg + 1'b1;
				if (tx_reg[7]) begin
					if (cnt_reg == CNT_W'(ONE_PULSE_AT - 1)) begin
						out_next = 1'b1; // RULE8
						oen_next = 1'b0;
					end
				end else if (cnt_reg < CNT_W'(ZERO_LOW_CYCLES - 1)) begin
					oen_next = 1'b0; // RULE9
				end else if (cnt_reg == CNT_W'(ZERO_LOW_CYCLES - 1)) begin
					out_next = 1'b1; // RULE9
					oen_next = 1'b0;
				end
				if (cnt_reg == CNT_W'(BIT_CYCLES - 1)) begin
					st_next  = S_IDLE;
					tx_next  = {tx_reg[6:0], 1'b0}; // RULE2
					bit_next = bit_reg + 1'b1;
					if (bit_reg == 3'd7) begin
						txon_next = 1'b0;
					end
				end
			end
			S_SYWT: begin
				if (sync2_reg) begin
					st_next  = S_SYDL; // RULE17
					cnt_next = '0;
				end
			end
			S_SYDL: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(SYNC_DELAY - 1)) begin
					st_next  = S_SYLO;
					cnt_next = '0;
					// Drive starts here so the low run is a full 128 cycles
					oen_next = 1'b0; // RULE17
				end
			end
			S_SYLO: begin
				cnt_next = cnt_reg + 1'b1;
				oen_next = 1'b0; // RULE17
				if (cnt_reg == CNT_W'(SYNC_LOW - 1)) begin
					st_next  = S_SYHI;
					out_next = 1'b1;
				end
			end
			S_SYHI: begin
				st_next  = S_IDLE; // RULE17
				sd_next  = 1'b1;
				bit_next = '0;
			end
			default: begin
				st_next = S_IDLE;
			end
		endcase
		// Placed after the bit logic so a new command start wins over a clear
		if (cmd_start) begin
			first_next = 1'b1; // RULE18
		end
		// Timeout drops partial and queued bytes and rearms command decode; mode stays untouched
		if (idle_reg == CNT_W'(TIMEOUT) && !fall && st_reg != S_SYWT
			&& st_reg != S_SYDL && st_reg != S_SYLO) begin
			st_next   = S_IDLE; // RULE3
			bit_next  = '0;
			txon_next = 1'b0;
			first_next = 1'b1;
			ab_next   = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg    <= S_IDLE;
			cnt_reg   <= '0;
			idle_reg  <= '0;
			bit_reg   <= '0;
			sh_reg    <= 8'h00;
			tx_reg    <= 8'h00;
			txon_reg  <= 1'b0;
			first_reg <= 1'b1;
			abm_reg   <= 1'b0;
			out_reg   <= 1'b0;
			oen_reg   <= 1'b1;
			rxv_reg   <= 1'b0;
			cv_reg    <= 1'b0;
			rj_reg    <= 1'b0;
			ab_reg    <= 1'b0;
			sd_reg    <= 1'b0;
			boot_reg  <= 1'b1;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			idle_reg  <= idle_next;
			bit_reg   <= bit_next;
			sh_reg    <= sh_next;
			tx_reg    <= tx_next;
			txon_reg  <= txon_next;
			first_reg <= first_next;
			out_reg   <= out_next;
			oen_reg   <= oen_next;
			rxv_reg   <= rxv_next;
			cv_reg    <= cv_next;
			rj_reg    <= rj_next;
			ab_reg    <= ab_next;
			sd_reg    <= sd_next;
			boot_reg  <= 1'b0;
			// Pin level caught on the first edge after release; pullup means run (RULE12)
			abm_reg   <= boot_reg ? ~link.debug_pin : abm_next; // RULE12 RULE13
		end
	end

	assign link.tgt_pin_out  = out_reg;
	assign link.tgt_pin_oe_n = oen_reg;
	assign tx_ready          = ~txon_reg;
	assign rx_valid          = rxv_reg;
	assign rx_byte           = sh_reg;
	assign cmd_valid         = cv_reg;
	assign cmd_code          = sh_reg;
	assign cmd_rejected      = rj_reg;
	assign cmd_abort         = ab_reg;
	assign sync_done         = sd_reg;
	assign active_background_mode = abm_reg;
endmodule

// ==== shared/dbg_link_if.sv ====
// Single-wire debug pin joining host and target
`timescale 1ns/100ps
interface dbg_link_if;
	// Target pin drive
	logic tgt_pin_out;
	logic tgt_pin_oe_n;
	// Host pin drive
	logic host_pin_out;
	logic host_pin_oe_n;
	// Resolved line with pullup
	logic debug_pin;

	assign debug_pin = (!tgt_pin_oe_n) ? tgt_pin_out :
		(!host_pin_oe_n) ? host_pin_out : 1'b1;

	modport target (input debug_pin, output tgt_pin_out, output tgt_pin_oe_n);
	modport host (input debug_pin, output host_pin_out, output host_pin_oe_n);
endinterface

// ==== shared/dbg_link_pkg.sv ====
// Shared constants for the single-wire debug bit link
package dbg_link_pkg;
	localparam int          BIT_CYCLES      = 16;
	localparam int          SAMPLE_AT       = 10;
	localparam int          ONE_PULSE_AT    = 7;
	localparam int          ZERO_LOW_CYCLES = 13;
	localparam int          TIMEOUT_CYCLES  = 512;
	localparam int          SYNC_DETECT     = 128;
	localparam int          SYNC_DELAY      = 16;
	localparam int          SYNC_LOW        = 128;
	localparam int          HOST_LOW_CYCLES = 2;
	localparam int          HOST_SAMPLE_AT  = 10;
	localparam int          CMD_DELAY       = 16;
	localparam int          CNT_W           = 10;
	localparam logic [7:0]  DSC_RESET       = 8'h00;
	localparam int          DSC_CLKSEL_BIT  = 0;
	localparam logic [1:0]  GRP_NONINTRUSIVE = 2'h0;
	localparam logic [1:0]  GRP_ACTIVE       = 2'h1;
	localparam logic [7:0]  CMD_ACTIVE_MASK  = 8'h80;
endpackage

// ==== test/dbg_link_monitor.sv ====
// Checker on the debug pin between host and target ends
`timescale 1ns/100ps
module dbg_link_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin drives and line
	input wire logic tgt_pin_out,
	input wire logic tgt_pin_oe_n,
	input wire logic host_pin_out,
	input wire logic host_pin_oe_n,
	input wire logic debug_pin
);
	logic       t_low;
	logic       t_high;
	logic       pin_reg;
	logic       pin_next;
	logic [9:0] run_reg;
	logic [9:0] run_next;
	logic [9:0] fall_reg;
	logic [9:0] fall_next;

	assign t_low = !tgt_pin_oe_n && !tgt_pin_out;
	assign t_high = !tgt_pin_oe_n && tgt_pin_out;

	// Saturates so a long idle line never wraps back into a timing window
	always_comb begin
		pin_next = debug_pin;
		run_next = t_low ? run_reg + 10'h001 : 10'h000;
		fall_next = (pin_reg && !debug_pin) ? 10'h000 :
			fall_reg + {9'h000, fall_reg != 10'h3ff};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_reg <= 1'b1;
			run_reg <= 10'h000;
			fall_reg <= 10'h3ff;
		end else begin
			pin_reg <= pin_next;
			run_reg <= run_next;
			fall_reg <= fall_next;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_no_fight: assert property (!(!tgt_pin_oe_n && !host_pin_oe_n && tgt_pin_out != host_pin_out))
		else $error("both ends drive opposite levels");
	a_quiet_host_send: assert property (!host_pin_oe_n && host_pin_out |-> tgt_pin_oe_n)
		else $error("target drives while host drives high");
	a_pulse_brief: assert property (t_high |=> tgt_pin_oe_n)
		else $error("target high drive longer than one cycle");
	a_zero_hold: assert property ($rose(t_low) |-> t_low [*8] ##1 t_low [*5])
		else $error("target low drive shorter than 13 cycles");
	a_low_run: assert property ($fell(t_low) |-> run_reg == 10'h00d || run_reg == 10'h080)
		else $error("target low run has wrong length");
	a_low_then_high: assert property ($fell(t_low) |-> t_high)
		else $error("no speedup pulse after target low");
	a_one_timing: assert property (t_high && $past(tgt_pin_oe_n) |-> fall_reg >= 10'h005 && fall_reg <= 10'h00b)
		else $error("logic one pulse off its slot");
	a_start_align: assert property ($rose(t_low) |-> fall_reg <= 10'h004 || fall_reg >= 10'h08c)
		else $error("target low starts off the bit start");
endmodule

// ==== test/test_single_wire_debug_bit_link.sv ====
// Testbench joining host and target ends of the debug bit link
`timescale 1ns/100ps
module test_single_wire_debug_bit_link;
	import dbg_link_pkg::*;
	// Short timeout keeps idle waits brief, yet outlasts a sync request
	localparam int TMO = 256;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic [7:0]       dsc = 8'h00;
	logic             tx_valid = 1'b0;
	logic [7:0]       tx_byte = 8'h00;
	logic             cmd_start = 1'b0;
	logic             enter_bg = 1'b0;
	logic             leave_bg = 1'b0;
	logic             req_valid = 1'b0;
	logic             req_read = 1'b0;
	logic             req_sync = 1'b0;
	logic [7:0]       req_byte = 8'h00;
	logic [CNT_W-1:0] bit_time = 10'h014;
	logic             clk_sel, tx_ready, rx_valid, cmd_valid, cmd_rejected, cmd_abort;
	logic             sync_done, bg_mode, req_ready, rsp_valid;
	logic [7:0]       rx_byte, cmd_code, rsp_byte;
	logic [CNT_W-1:0] sync_len;
	int               errors = 0;
	int               checked = 0;
	int               n_cmd = 0, n_rej = 0, n_abt = 0, n_sync = 0, n_rx = 0, n_rsp = 0;
	int               c0, a0, i;
	logic [7:0]       codes [7] = '{8'h08, 8'h10, 8'h18, 8'h68, 8'h48, 8'h4b, 8'he0};
	logic [7:0]       rdat [4] = '{8'ha5, 8'h00, 8'hff, 8'h01};

	always #2.5 clk = ~clk;

	dbg_link_if link ();
	dbg_link_target #(.TIMEOUT(TMO)) i_dbg_link_target (.clk(clk), .alt_clk(clk), .rst(rst),
		.link(link), .debug_status_control(dsc), .debug_clock_source_select(clk_sel),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
		.cmd_rejected(cmd_rejected), .cmd_abort(cmd_abort), .sync_done(sync_done),
		.cmd_start(cmd_start), .enter_background(enter_bg), .leave_background(leave_bg),
		.active_background_mode(bg_mode));
	dbg_link_host i_dbg_link_host (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
		.req_read(req_read), .req_sync(req_sync), .req_byte(req_byte), .bit_time(bit_time),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .sync_len(sync_len));
	dbg_link_monitor u_mon (.clk(clk), .rst(rst), .tgt_pin_out(link.tgt_pin_out),
		.tgt_pin_oe_n(link.tgt_pin_oe_n), .host_pin_out(link.host_pin_out),
		.host_pin_oe_n(link.host_pin_oe_n), .debug_pin(link.debug_pin));

	always @(posedge clk) begin
		n_cmd += int'(cmd_valid === 1'b1);
		n_rej += int'(cmd_rejected === 1'b1);
		n_abt += int'(cmd_abort === 1'b1);
		n_sync += int'(sync_done === 1'b1);
		n_rx += int'(rx_valid === 1'b1);
		n_rsp += int'(rsp_valid === 1'b1);
	end

	task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task tick();
		@(posedge clk);
		#1;
	endtask

	// Holds the request until the edge that takes it, then waits for idle
	task host_op(input logic rd, input logic sy, input logic [7:0] b);
		int n;
		req_read = rd;
		req_sync = sy;
		req_byte = b;
		req_valid = 1'b1;
		for (n = 0; n < 50 && req_ready !== 1'b1; n++) tick();
		tick();
		req_valid = 1'b0;
		for (n = 0; n < 3000 && req_ready !== 1'b1; n++) tick();
		chk("host idle", 10'h001, {9'h000, req_ready});
		tick();
	endtask

	task cmd(input logic [7:0] c, input logic acc);
		c0 = n_cmd;
		a0 = n_rej;
		cmd_start = 1'b1;
		tick();
		cmd_start = 1'b0;
		host_op(1'b0, 1'b0, c);
		chk("accepted", {9'h000, acc}, 10'(n_cmd - c0));
		chk("rejected", {9'h000, !acc}, 10'(n_rej - a0));
		if (acc) chk("cmd_code", {2'h0, c}, {2'h0, cmd_code});
	endtask

	task rd(input logic [7:0] b);
		int n;
		tx_byte = b;
		tx_valid = 1'b1;
		for (n = 0; n < 50 && tx_ready !== 1'b1; n++) tick();
		tick();
		tx_valid = 1'b0;
		c0 = n_rsp;
		host_op(1'b1, 1'b0, 8'h00);
		chk("rsp_byte", {2'h0, b}, {2'h0, rsp_byte});
		chk("rsp_valid", 10'h001, 10'(n_rsp - c0));
	endtask

	task pulse(input logic enter);
		enter_bg = enter;
		leave_bg = !enter;
		tick();
		enter_bg = 1'b0;
		leave_bg = 1'b0;
	endtask

	task stop_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		stop_test();
	end

	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		tick();
		tick();
		chk("mode after reset", 10'h000, {9'h000, bg_mode});
		chk("pin released", 10'h001, {9'h000, link.tgt_pin_oe_n});
		dsc = 8'h01;
		tick();
		chk("clock select", 10'h001, {9'h000, clk_sel});
		dsc = 8'h00;
		tick();
		chk("clock select", 10'h000, {9'h000, clk_sel});
		$display("test reset done");
		cmd(8'he4, 1'b1);
		c0 = n_rx;
		host_op(1'b0, 1'b0, 8'h5a);
		chk("rx_byte", 10'h05a, {2'h0, rx_byte});
		chk("rx_valid", 10'h001, 10'(n_rx - c0));
		cmd(8'h68, 1'b0);
		$display("test run mode done");
		pulse(1'b1);
		chk("mode", 10'h001, {9'h000, bg_mode});
		for (i = 0; i < 7; i++) cmd(codes[i], 1'b1);
		$display("test background done");
		cmd(8'he0, 1'b1);
		for (i = 0; i < 4; i++) rd(rdat[i]);
		$display("test read done");
		cmd(8'hc4, 1'b1);
		a0 = n_abt;
		repeat (TMO + 40) tick();
		chk("abort", 10'h001, 10'(n_abt - a0));
		chk("mode kept", 10'h001, {9'h000, bg_mode});
		c0 = n_cmd;
		host_op(1'b0, 1'b0, 8'he8);
		chk("cmd after abort", 10'h001, 10'(n_cmd - c0));
		$display("test timeout done");
		a0 = n_sync;
		host_op(1'b0, 1'b1, 8'h00);
		chk("sync done", 10'h001, 10'(n_sync - a0));
		chk("sync_len", 10'(SYNC_LOW), sync_len);
		pulse(1'b0);
		chk("mode", 10'h000, {9'h000, bg_mode});
		$display("test sync done");
		stop_test();
	end
endmodule
